// [pkg/pma_consts.vh]
// constants of the protection master aggregator: register map, fields, codes
// assumes byte addressing on an 8-bit AXI4-Lite address window
`ifndef PMA_CONSTS_VH
`define PMA_CONSTS_VH
// ****************************************
// register byte addresses
// ****************************************
`define PMA_A_CTRL 8'h00
`define PMA_A_SUPERV 8'h04
`define PMA_A_DIR_EN 8'h08
`define PMA_A_DIR_REV 8'h0C
`define PMA_A_DIR_GND 8'h10
`define PMA_A_PH_CAP 8'h14
`define PMA_A_MTA 8'h18
`define PMA_A_STATUS 8'h1C
`define PMA_A_ELEM 8'h20
`define PMA_A_BRK_BASE 8'h40
`define PMA_A_DLY_BASE 8'h80
// ****************************************
// control fields and reset values
// ****************************************
`define PMA_C_FEN 0
`define PMA_C_XBEN 1
`define PMA_C_PSUP 2
`define PMA_C_XSEN 3
`define PMA_CTRL_W 4
`define PMA_CTRL_RST 4'h1
`define PMA_DLY_RST 16'h0064
`define PMA_MTA_RST 16'h0000
// ****************************************
// status fields
// ****************************************
`define PMA_S_GALM 0
`define PMA_S_GTRP 1
`define PMA_S_PALM 2
`define PMA_S_PTRP 5
`define PMA_S_PDIR 8
`define PMA_S_LPDIR 10
`define PMA_S_LGDIR 12
`define PMA_S_BLK 14
`define PMA_S_SUP 15
`define PMA_EL_ALM 0
`define PMA_EL_TRP 8
`define PMA_EL_CMD 16
// ****************************************
// direction codes and bus responses
// ****************************************
`define PMA_DIR_NONE 2'h0
`define PMA_DIR_FWD 2'h1
`define PMA_DIR_REV 2'h2
`define PMA_RESP_OK 2'h0
`define PMA_RESP_ERR 2'h2
`endif

// [sim/pma_checker.sv]
// checker: port relations of the protection aggregator
// assumes a bind onto pma_top, single clock aclk
`timescale 1ns/1ps
`default_nettype none
module pma_checker #(
  parameter N = 4,
  parameter NB = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched inputs
  input wire logic [N-1:0] fault_in,
  input wire logic mag_ok_in,
  // watched outputs
  input wire logic [N-1:0] elem_alarm_r,
  input wire logic [N-1:0] elem_trip_r,
  input wire logic [N-1:0] trip_command_r,
  input wire logic general_alarm_r,
  input wire logic general_trip_r,
  input wire logic [2:0] phase_alarm_r,
  input wire logic [2:0] phase_trip_r,
  input wire logic [NB-1:0] breaker_trip_r,
  input wire logic [1:0] phase_dir_r
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************
  // sequences
  // ****************
  sequence s_no_mag;
    !mag_ok_in;
  endsequence
  sequence s_dir_none;
    phase_dir_r == 2'h0;
  endsequence
  // ****************
  // properties
  // ****************
  a_alarm_cause: assert property ((elem_alarm_r & ~$past(fault_in)) == '0)
    else $error("element alarm without criterion");
  a_trip_alarm: assert property ((elem_trip_r & ~elem_alarm_r) == '0)
    else $error("element trip without alarm");
  a_cmd_trip: assert property ((trip_command_r & ~elem_trip_r) == '0)
    else $error("command without trip");
  a_gen_alarm: assert property (general_alarm_r |-> |elem_alarm_r)
    else $error("general alarm without element alarm");
  a_gen_trip: assert property (general_trip_r |-> |elem_trip_r)
    else $error("general trip without element trip");
  a_phase_alarm: assert property (|phase_alarm_r |-> general_alarm_r)
    else $error("phase alarm without general alarm");
  a_phase_trip: assert property (|phase_trip_r |-> general_trip_r)
    else $error("phase trip without general trip");
  a_breaker_cmd: assert property (|breaker_trip_r |-> |trip_command_r)
    else $error("breaker trip without command");
  a_dir_none: assert property (s_no_mag |=> s_dir_none)
    else $error("direction given on small phasors");
endmodule // pma_checker
bind pma_top pma_checker #(.N(N), .NB(NB)) chk_u (
  .aclk, .aresetn, .fault_in, .mag_ok_in, .elem_alarm_r, .elem_trip_r, .trip_command_r,
  .general_alarm_r, .general_trip_r, .phase_alarm_r, .phase_trip_r, .breaker_trip_r,
  .phase_dir_r
);
`default_nettype wire

// [sim/pma_elem_model.sv]
// far-side model: protective element criteria feeding the aggregator
// assumes requests change just after a rising aclk edge
`timescale 1ns/1ps
`default_nettype none
module pma_elem_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // criteria asked for by the bench
  input wire logic slow,
  input wire logic [3:0] crit_req,
  input wire logic [11:0] phase_req,
  // toward the aggregator
  output logic [3:0] fault_in,
  output logic [11:0] phase_fault_in
);
  logic [15:0] hold_r;
  logic [15:0] now_nxt;
  assign now_nxt = aresetn ? {phase_req, crit_req} : 16'h0000;
  // slow elements answer a cycle later, like a filtered detector
  always @(posedge aclk)
  begin
    hold_r <= now_nxt;
    {phase_fault_in, fault_in} <= slow ? hold_r : now_nxt;
  end
endmodule // pma_elem_model
`default_nettype wire

// [sim/pma_tb_top.sv]
// testbench: aggregator driven over its register bus and element model
// assumes pma_top, the element model and the bound checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pma_consts.vh"
module pma_tb_top;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [3:0] sup;
    logic [3:0] flt;
    logic [3:0] alm;
    logic [3:0] trp;
    logic [3:0] cmd;
  } pma_row_t;
  logic aclk, aresetn, slow, mag_ok_in, general_alarm_r, general_trip_r;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic external_block_input_a, external_block_input_b, external_trip_suppress_input;
  logic [1:0] s_axi_bresp, s_axi_rresp, ground_dir_in, phase_dir_r, lat_phase_dir_r;
  logic [1:0] lat_ground_dir_r, breaker_trip_r;
  logic [2:0] phase_alarm_r, phase_trip_r;
  logic [3:0] s_axi_wstrb, fault_in, crit_req, elem_alarm_r, elem_trip_r, trip_command_r;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [11:0] phase_fault_in, phase_req;
  logic [15:0] op_angle_in;
  logic [17:0] dirs [5];
  logic [31:0] s_axi_wdata, s_axi_rdata;
  pma_row_t rows [6];
  int err_count, samples_checked;
  pma_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_in, .phase_fault_in,
    .external_block_input_a, .external_block_input_b, .external_trip_suppress_input,
    .mag_ok_in, .op_angle_in, .ground_dir_in, .elem_alarm_r, .elem_trip_r,
    .trip_command_r, .general_alarm_r, .general_trip_r, .phase_alarm_r, .phase_trip_r,
    .breaker_trip_r, .phase_dir_r, .lat_phase_dir_r, .lat_ground_dir_r);
  pma_elem_model model_u (.aclk, .aresetn, .slow, .crit_req, .phase_req, .fault_in,
    .phase_fault_in);
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ****************
  // checks and bus tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("err_count %0d samples_checked %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 200)
    begin
      err_count++;
      $display("mismatch t=%0t bus wait ran out", $time);
      complete_run();
    end
  endtask
  // both channels offered together, each dropped on its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw || w || s_axi_bvalid !== 1'b1) && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    bound(n);
    chk(s_axi_bresp, r, "bresp");
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    logic ar;
    @(posedge aclk);
    ar = 1'b1;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while ((ar || s_axi_rvalid !== 1'b1) && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (ar && s_axi_arready === 1'b1)
      begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
    bound(n);
    chk(s_axi_rdata, e, "rdata");
    chk(s_axi_rresp, r, "rresp");
  endtask
  task automatic outs(input logic [3:0] a, input logic [3:0] t, input logic [3:0] c,
    input logic [3:0] s);
    chk(elem_alarm_r, a, "alarm");
    chk(elem_trip_r, t, "trip");
    chk(trip_command_r, c, "command");
    chk(general_alarm_r, |(a & ~s), "gen alarm");
    chk(general_trip_r, |(t & ~s), "gen trip");
    chk(breaker_trip_r, {|(c & 4'hC), |(c & 4'h3)}, "breaker");
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    {aresetn, slow, mag_ok_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {external_block_input_a, external_block_input_b, external_trip_suppress_input} = '0;
    {crit_req, phase_req, op_angle_in, ground_dir_in} = '0;
    s_axi_wstrb = 4'hF;
    err_count = 0;
    samples_checked = 0;
    rows = '{24'h105555, 24'h00F000, 24'h503330, 24'h123331, 24'h1F8880, 24'h30FFFF};
    dirs = '{{16'h4000, 2'h1}, {16'h8000, 2'h2}, {16'h0000, 2'h1}, {16'hC000, 2'h2},
      {16'h7FFF, 2'h1}};
    waitc(20);
    aresetn <= 1'b1;
    waitc(2);
    outs(4'h0, 4'h0, 4'h0, 4'h0);
    rchk(`PMA_A_CTRL, `PMA_CTRL_RST, `PMA_RESP_OK);
    rchk(`PMA_A_DLY_BASE, `PMA_DLY_RST, `PMA_RESP_OK);
    rchk(8'h30, 32'h0, `PMA_RESP_ERR);
    wr(`PMA_A_STATUS, 32'hFFFF, `PMA_RESP_ERR);
    for (int i = 0; i < 4; i++)
      wr(`PMA_A_DLY_BASE + 8'(4 * i), 32'h2);
    wr(`PMA_A_BRK_BASE, 32'h3);
    wr(`PMA_A_BRK_BASE + 8'h04, 32'hC);
    slow <= 1'b1;
    foreach (rows[i])
    begin
      wr(`PMA_A_CTRL, 32'(rows[i].ctrl));
      wr(`PMA_A_SUPERV, 32'(rows[i].sup));
      crit_req <= rows[i].flt;
      waitc(10);
      outs(rows[i].alm, rows[i].trp, rows[i].cmd, rows[i].sup);
      crit_req <= 4'h0;
      waitc(4);
      outs(4'h0, 4'h0, 4'h0, 4'h0);
    end
    // short bursts must never add up to a full delay
    slow <= 1'b0;
    wr(`PMA_A_CTRL, 32'h1);
    wr(`PMA_A_SUPERV, 32'h0);
    wr(`PMA_A_DLY_BASE, 32'h3);
    for (int i = 0; i < 12; i++)
    begin
      crit_req <= {3'b000, 12'b0000_0001_1011 >> i};
      waitc(1);
      chk(elem_trip_r[0], 1'b0, "early trip");
    end
    crit_req <= 4'h1;
    waitc(5);
    chk(elem_alarm_r[0] & ~elem_trip_r[0], 1'b1, "alarm before trip");
    waitc(1);
    chk(elem_trip_r[0], 1'b1, "trip at delay");
    crit_req <= 4'h0;
    wr(`PMA_A_CTRL, 32'h3);
    external_block_input_a <= 1'b1;
    waitc(4);
    crit_req <= 4'h1;
    waitc(10);
    outs(4'h0, 4'h0, 4'h0, 4'h0);
    external_block_input_a <= 1'b0;
    external_block_input_b <= 1'b1;
    waitc(10);
    outs(4'h0, 4'h0, 4'h0, 4'h0);
    external_block_input_b <= 1'b0;
    waitc(12);
    outs(4'h1, 4'h1, 4'h1, 4'h0);
    wr(`PMA_A_CTRL, 32'h9);
    external_trip_suppress_input <= 1'b1;
    waitc(6);
    outs(4'h1, 4'h1, 4'h0, 4'h0);
    external_trip_suppress_input <= 1'b0;
    waitc(6);
    outs(4'h1, 4'h1, 4'h1, 4'h0);
    wr(`PMA_A_PH_CAP, 32'h1);
    crit_req <= 4'h3;
    phase_req <= 12'h00A;
    waitc(10);
    chk(phase_alarm_r, 3'b010, "phase alarm");
    chk(phase_trip_r, 3'b010, "phase trip");
    wr(`PMA_A_SUPERV, 32'h1);
    waitc(3);
    chk(phase_alarm_r, 3'b000, "phase of supervision element");
    crit_req <= 4'h0;
    phase_req <= 12'h000;
    wr(`PMA_A_SUPERV, 32'h0);
    wr(`PMA_A_MTA, 32'h4000);
    mag_ok_in <= 1'b1;
    foreach (dirs[i])
    begin
      op_angle_in <= dirs[i][17:2];
      waitc(3);
      chk(phase_dir_r, dirs[i][1:0], "phase direction");
    end
    mag_ok_in <= 1'b0;
    waitc(3);
    chk(phase_dir_r, `PMA_DIR_NONE, "no direction");
    mag_ok_in <= 1'b1;
    wr(`PMA_A_DIR_EN, 32'h2);
    wr(`PMA_A_DIR_REV, 32'h0);
    op_angle_in <= 16'h8000;
    crit_req <= 4'h2;
    waitc(6);
    chk(elem_alarm_r, 4'h0, "wrong direction");
    op_angle_in <= 16'h4000;
    ground_dir_in <= `PMA_DIR_FWD;
    waitc(6);
    chk(elem_alarm_r, 4'h2, "right direction");
    chk(lat_ground_dir_r, `PMA_DIR_FWD, "latched ground");
    crit_req <= 4'h0;
    waitc(4);
    op_angle_in <= 16'h8000;
    ground_dir_in <= `PMA_DIR_REV;
    waitc(4);
    chk(phase_dir_r, `PMA_DIR_REV, "live direction");
    chk(lat_phase_dir_r, `PMA_DIR_FWD, "latched phase held");
    chk(lat_ground_dir_r, `PMA_DIR_FWD, "latched ground held");
    complete_run();
  end
endmodule // pma_tb_top
`default_nettype wire

// [verilog/pma_top.v]
// protection master aggregator: blocking, delay timers, collectives, trip routing
// assumes element criteria and angle inputs come from logic on aclk
`timescale 1ns/1ps
`default_nettype none
`include "pma_consts.vh"
// Function
// [R1] function inactive or master blocked makes every element ineffective
// [R2] external blocking enabled: either blocking input blocks all protection
// [R3] permanent suppress blocks trip commands, alarms and trips continue
// [R4] external suppress enabled: suppress input blocks all trip commands
// [R5] element decisions reach collectives only when not supervision-only
// [R6] supervision-only element keeps local states, no command, no collectives
// [R7] element alarm follows its fault criterion
// [R8] element trips when criterion persists through its full delay
// [R9] general alarm is OR of forwarded element alarms
// [R10] general trip is OR of forwarded element trips
// [R11] trip command issued on trip unless commands are suppressed
// [R12] one trip manager per breaker ORs its assigned element commands
// [R13] single-phase capable forwarded elements add per-phase alarms and trips
// [R14] per phase collective alarm and trip are ORs over elements
// [R15] small phasor magnitudes report direction not possible
// [R16] directional elements trip only for matching fault direction
// [R17] forward or reverse decided by side of perpendicular characteristic
// [R18] phase direction published always, both directions latched on faults
// [R19] forward when operating angle within characteristic angle plus minus 90
// [R20] delay timer restarts on criterion drop or any blocking
// [R21] whole protection blocked holds all alarms, trips and commands low
module pma_top #(
  parameter N = 4,
  parameter NB = 2,
  parameter DW = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // element criteria and phases
  input wire [N-1:0] fault_in,
  input wire [3*N-1:0] phase_fault_in,
  // blocking pins, asynchronous
  input wire external_block_input_a,
  input wire external_block_input_b,
  input wire external_trip_suppress_input,
  // direction inputs
  input wire mag_ok_in,
  input wire [15:0] op_angle_in,
  input wire [1:0] ground_dir_in,
  // element and collective outputs
  output reg [N-1:0] elem_alarm_r,
  output reg [N-1:0] elem_trip_r,
  output reg [N-1:0] trip_command_r,
  output reg general_alarm_r,
  output reg general_trip_r,
  output reg [2:0] phase_alarm_r,
  output reg [2:0] phase_trip_r,
  output reg [NB-1:0] breaker_trip_r,
  // direction outputs
  output reg [1:0] phase_dir_r,
  output reg [1:0] lat_phase_dir_r,
  output reg [1:0] lat_ground_dir_r
);

  // ****************************************
  // functions
  // ****************************************
  // array region hit, used by both read and write decode
  function in_region;
    input [7:0] addr;
    input [7:0] base;
    input integer cnt;
    begin
      in_region = (addr[7:6] == base[7:6]) && (addr[1:0] == 2'h0) &&
        ({28'h0, addr[5:2]} < cnt);
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          wmerge[8*k +: 8] = data[8*k +: 8];
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [`PMA_CTRL_W-1:0] ctrl_r;
  reg [N-1:0] superv_r;
  reg [N-1:0] dir_en_r;
  reg [N-1:0] dir_rev_r;
  reg [N-1:0] dir_gnd_r;
  reg [N-1:0] ph_cap_r;
  reg [15:0] mta_r;
  reg [DW-1:0] delay_r [0:N-1];
  reg [N-1:0] brk_map_r [0:NB-1];
  reg [DW-1:0] cnt_r [0:N-1];
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  integer i;
  integer p;
  // each loop index is used in one process only, so no variable has two drivers
  integer ic;
  integer iw;
  integer ir;

  // ****************************************
  // blocking and direction
  // ****************************************
  wire prot_blk;
  wire supp;
  wire [15:0] ang_diff;
  reg [1:0] pdir;
  reg [N-1:0] crit;
  reg [N-1:0] trip_now;
  reg [N-1:0] cmd;
  reg [N-1:0] fwd;
  reg [2:0] palm;
  reg [2:0] ptrp;
  reg [NB-1:0] brk;
  reg [1:0] edir;

  // only the second stage of the synchroniser is read
  assign prot_blk = ~ctrl_r[`PMA_C_FEN] |
    (ctrl_r[`PMA_C_XBEN] & (sync2_r[0] | sync2_r[1])); // [R1] [R2]
  assign supp = ctrl_r[`PMA_C_PSUP] |
    (ctrl_r[`PMA_C_XSEN] & sync2_r[2]); // [R3] [R4]
  // binary angle: full circle is 2^16, so the top two bits give the half-plane
  assign ang_diff = op_angle_in - mta_r;

  always @*
  begin
    if (!mag_ok_in)
      pdir = `PMA_DIR_NONE; // [R15]
    else if (ang_diff[15] == ang_diff[14])
      pdir = `PMA_DIR_FWD; // [R17] [R19]
    else
      pdir = `PMA_DIR_REV; // [R17] [R19]
  end

  // ****************************************
  // element logic and collectives
  // ****************************************
  always @*
  begin
    edir = `PMA_DIR_NONE;
    fwd = ~superv_r; // [R5]
    for (i = 0; i < N; i = i + 1)
    begin
      edir = dir_gnd_r[i] ? ground_dir_in : pdir;
      // a not-possible direction never matches, so it holds off a trip
      crit[i] = fault_in[i] & ~prot_blk & (~dir_en_r[i] |
        (edir == (dir_rev_r[i] ? `PMA_DIR_REV : `PMA_DIR_FWD))); // [R16] [R21]
      trip_now[i] = crit[i] & (cnt_r[i] >= delay_r[i]); // [R8]
    end
    cmd = trip_now & fwd & {N{~supp}}; // [R6] [R11]
    for (p = 0; p < 3; p = p + 1)
    begin
      palm[p] = 1'b0;
      ptrp[p] = 1'b0;
      for (i = 0; i < N; i = i + 1)
      begin
        palm[p] = palm[p] | (crit[i] & fwd[i] & ph_cap_r[i] &
          phase_fault_in[3*i+p]); // [R13] [R14]
        ptrp[p] = ptrp[p] | (trip_now[i] & fwd[i] & ph_cap_r[i] &
          phase_fault_in[3*i+p]); // [R13] [R14]
      end
    end
    for (i = 0; i < NB; i = i + 1)
      brk[i] = |(cmd & brk_map_r[i]); // [R12]
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      elem_alarm_r <= {N{1'b0}};
      elem_trip_r <= {N{1'b0}};
      trip_command_r <= {N{1'b0}};
      general_alarm_r <= 1'b0;
      general_trip_r <= 1'b0;
      phase_alarm_r <= 3'h0;
      phase_trip_r <= 3'h0;
      breaker_trip_r <= {NB{1'b0}};
      phase_dir_r <= `PMA_DIR_NONE;
      lat_phase_dir_r <= `PMA_DIR_NONE;
      lat_ground_dir_r <= `PMA_DIR_NONE;
      for (ic = 0; ic < N; ic = ic + 1)
        cnt_r[ic] <= {DW{1'b0}};
    end
    else
    begin
      sync1_r <= {external_trip_suppress_input, external_block_input_b,
        external_block_input_a};
      sync2_r <= sync1_r;
      for (ic = 0; ic < N; ic = ic + 1)
        if (!crit[ic])
          cnt_r[ic] <= {DW{1'b0}}; // [R20]
        else if (cnt_r[ic] < delay_r[ic])
          cnt_r[ic] <= cnt_r[ic] + 1'b1; // [R8]
      elem_alarm_r <= crit; // [R7] [R6]
      elem_trip_r <= trip_now; // [R8] [R6]
      trip_command_r <= cmd; // [R11] [R3] [R4]
      general_alarm_r <= |(crit & fwd); // [R9]
      general_trip_r <= |(trip_now & fwd); // [R10]
      phase_alarm_r <= palm; // [R14]
      phase_trip_r <= ptrp; // [R14]
      breaker_trip_r <= brk; // [R12]
      phase_dir_r <= pdir; // [R18]
      if (|crit)
      begin
        lat_phase_dir_r <= pdir; // [R18]
        lat_ground_dir_r <= ground_dir_in; // [R18]
      end
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  wire do_write;
  reg wr_hit;
  reg [31:0] rd_val;
  reg rd_hit;

  assign do_write = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMA_RESP_OK;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      ctrl_r <= `PMA_CTRL_RST;
      superv_r <= {N{1'b0}};
      dir_en_r <= {N{1'b0}};
      dir_rev_r <= {N{1'b0}};
      dir_gnd_r <= {N{1'b0}};
      ph_cap_r <= {N{1'b0}};
      mta_r <= `PMA_MTA_RST;
      for (iw = 0; iw < N; iw = iw + 1)
        delay_r[iw] <= `PMA_DLY_RST;
      for (iw = 0; iw < NB; iw = iw + 1)
        brk_map_r[iw] <= {N{1'b0}};
    end
    else
    begin
      if (!aw_hold_r && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (!w_hold_r && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (s_axi_awready && s_axi_awvalid)
      begin
        awaddr_r <= s_axi_awaddr;
        aw_hold_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_hold_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PMA_RESP_OK : `PMA_RESP_ERR;
        case (awaddr_r)
          `PMA_A_CTRL: ctrl_r <= wr_new(`PMA_CTRL_W);
          `PMA_A_SUPERV: superv_r <= wm_n(superv_r);
          `PMA_A_DIR_EN: dir_en_r <= wm_n(dir_en_r);
          `PMA_A_DIR_REV: dir_rev_r <= wm_n(dir_rev_r);
          `PMA_A_DIR_GND: dir_gnd_r <= wm_n(dir_gnd_r);
          `PMA_A_PH_CAP: ph_cap_r <= wm_n(ph_cap_r);
          `PMA_A_MTA: mta_r <= wr_mta(mta_r);
          default:
          begin
            for (iw = 0; iw < N; iw = iw + 1)
              if (in_region(awaddr_r, `PMA_A_DLY_BASE, N) && awaddr_r[5:2] == iw)
                delay_r[iw] <= wr_dly(delay_r[iw]);
            for (iw = 0; iw < NB; iw = iw + 1)
              if (in_region(awaddr_r, `PMA_A_BRK_BASE, NB) && awaddr_r[5:2] == iw)
                brk_map_r[iw] <= wm_n(brk_map_r[iw]);
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // narrow write helpers: merge strobes into zero-extended old value
  function [N-1:0] wm_n;
    input [N-1:0] old;
    reg [31:0] t;
    begin
      t = wmerge({{(32-N){1'b0}}, old}, wdata_r, wstrb_r);
      wm_n = t[N-1:0];
    end
  endfunction

  function [`PMA_CTRL_W-1:0] wr_new;
    input integer w;
    reg [31:0] t;
    begin
      t = wmerge({{(32-`PMA_CTRL_W){1'b0}}, ctrl_r}, wdata_r, wstrb_r);
      wr_new = t[`PMA_CTRL_W-1:0];
    end
  endfunction

  function [15:0] wr_mta;
    input [15:0] old;
    reg [31:0] t;
    begin
      t = wmerge({16'h0, old}, wdata_r, wstrb_r);
      wr_mta = t[15:0];
    end
  endfunction

  function [DW-1:0] wr_dly;
    input [DW-1:0] old;
    reg [31:0] t;
    begin
      t = wmerge({{(32-DW){1'b0}}, old}, wdata_r, wstrb_r);
      wr_dly = t[DW-1:0];
    end
  endfunction

  always @*
  begin
    case (awaddr_r)
      `PMA_A_CTRL, `PMA_A_SUPERV, `PMA_A_DIR_EN, `PMA_A_DIR_REV,
      `PMA_A_DIR_GND, `PMA_A_PH_CAP, `PMA_A_MTA:
        wr_hit = 1'b1;
      default:
        wr_hit = in_region(awaddr_r, `PMA_A_DLY_BASE, N) |
          in_region(awaddr_r, `PMA_A_BRK_BASE, NB);
    endcase
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  // status registers are read-only; writes to them answer with an error
  always @*
  begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PMA_A_CTRL: rd_val[`PMA_CTRL_W-1:0] = ctrl_r;
      `PMA_A_SUPERV: rd_val[N-1:0] = superv_r;
      `PMA_A_DIR_EN: rd_val[N-1:0] = dir_en_r;
      `PMA_A_DIR_REV: rd_val[N-1:0] = dir_rev_r;
      `PMA_A_DIR_GND: rd_val[N-1:0] = dir_gnd_r;
      `PMA_A_PH_CAP: rd_val[N-1:0] = ph_cap_r;
      `PMA_A_MTA: rd_val[15:0] = mta_r;
      `PMA_A_STATUS:
      begin
        rd_val[`PMA_S_GALM] = general_alarm_r;
        rd_val[`PMA_S_GTRP] = general_trip_r;
        rd_val[`PMA_S_PALM +: 3] = phase_alarm_r;
        rd_val[`PMA_S_PTRP +: 3] = phase_trip_r;
        rd_val[`PMA_S_PDIR +: 2] = phase_dir_r;
        rd_val[`PMA_S_LPDIR +: 2] = lat_phase_dir_r;
        rd_val[`PMA_S_LGDIR +: 2] = lat_ground_dir_r;
        rd_val[`PMA_S_BLK] = prot_blk;
        rd_val[`PMA_S_SUP] = supp;
      end
      `PMA_A_ELEM:
      begin
        rd_val[`PMA_EL_ALM +: N] = elem_alarm_r; // [R6]
        rd_val[`PMA_EL_TRP +: N] = elem_trip_r; // [R6]
        rd_val[`PMA_EL_CMD +: N] = trip_command_r;
      end
      default:
      begin
        rd_hit = 1'b0;
        for (ir = 0; ir < N; ir = ir + 1)
          if (in_region(s_axi_araddr, `PMA_A_DLY_BASE, N) && s_axi_araddr[5:2] == ir)
          begin
            rd_val[DW-1:0] = delay_r[ir];
            rd_hit = 1'b1;
          end
        for (ir = 0; ir < NB; ir = ir + 1)
          if (in_region(s_axi_araddr, `PMA_A_BRK_BASE, NB) && s_axi_araddr[5:2] == ir)
          begin
            rd_val[N-1:0] = brk_map_r[ir];
            rd_hit = 1'b1;
          end
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PMA_RESP_OK;
    end
    else
    begin
      if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `PMA_RESP_OK : `PMA_RESP_ERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pma_top
`default_nettype wire
